// File: inc/chc_pkg.sv
`default_nettype none
package chc_pkg;
  localparam int SEG_W = 16;
  localparam int WORD_W = 64;
  localparam int OP_LSB = 12;
  localparam int ADDR_FLAG_BIT = 11;
  localparam int CT_RESET_BIT = 15;
  // Control register fields
  localparam int CT_MF_LSB = 13;
  localparam int CT_FF_LSB = 11;
  localparam int CT_XL_LSB = 9;
  localparam int CT_RAM_LOW_BIT = 8;
  localparam int CT_CAM_LSB = 6;
  localparam int CT_MASK_LSB = 4;
  localparam int CT_STEP_LSB = 2;
  localparam int CT_MODE_LSB = 0;
  localparam logic [15:0] CT_RESET = 16'h0000;
  localparam logic [1:0] FLAG_OFF = 2'h1;
  localparam logic [1:0] XLATE_ON = 2'h1;
  localparam logic [1:0] MASK_ONE = 2'h1;
  localparam logic [1:0] MASK_TWO = 2'h2;
  localparam logic [1:0] STEP_INC = 2'h1;
  localparam logic [1:0] STEP_DEC = 2'h2;
  localparam logic [1:0] MODE_ENH = 2'h1;
  // Segment control fields
  localparam int SC_DCUR = 0;
  localparam int SC_DSTART = 3;
  localparam int SC_DEND = 6;
  localparam int SC_SCUR = 8;
  localparam int SC_SSTART = 11;
  localparam int SC_SEND = 13;
  localparam logic [15:0] SC_RD_MASK = 16'h7BDB;
  localparam logic [15:0] SC_RESET = 16'h60C0;
  // Cascade selection
  localparam logic [15:0] DS_ALL = 16'hFFFF;
  localparam logic [15:0] DS_RESET = 16'h0000;
  localparam logic [15:0] PAGE_RESET = 16'h0000;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_TCO = 4'h1, OP_SPS = 4'h2, OP_SPD = 4'h3,
    OP_SFR = 4'h4, OP_SBR = 4'h5, OP_RSC = 4'h6, OP_CMP = 4'h7,
    OP_VALID = 4'h8, OP_MOVHPM = 4'h9, OP_MOVNF = 4'hA
  } chc_op_type;
  typedef enum logic [2:0] {
    T_CT = 3'h0, T_PA = 3'h1, T_SC = 3'h2, T_AR = 3'h3,
    T_NFA = 3'h4, T_DS = 3'h5, T_PS = 3'h6, T_PD = 3'h7
  } chc_tco_type;
  typedef enum logic [1:0] {
    RES_CR = 2'h0, RES_MR1 = 2'h1, RES_MR2 = 2'h2, RES_MEM = 2'h3
  } chc_res_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1, ST_ADDR = 2'h2
  } chc_state_type;
endpackage
`default_nettype wire

// File: src/chc_command_control.sv
`timescale 1ns/1ps
`default_nettype none
module chc_command_control #(
  parameter int DEPTH = 2048,
  parameter int AW = 11
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Host control bus
  input wire logic chipEnableN,
  input wire logic writeEnableN,
  input wire logic commandEnableN,
  // Host data bus
  input wire logic [15:0] hostBusIn,
  output logic [15:0] hostBusOut,
  output logic hostBusOe,
  // Daisy chain
  input wire logic chainEnableN,
  input wire logic chainMatchInN,
  input wire logic chainFullInN,
  output logic chainMatchOutN,
  output logic chainMatchOe,
  output logic chainFullOutN,
  // Local flags
  output logic localMatchN,
  output logic multiMatchN
);
  logic softRst, rstN, strobeQ, fall, rise;
  logic cmdWr, cmdRd, datWr, datRd, selOk, wrOk;
  logic bank, tcoOn, statusHi, cmpReq, locked, rdLive;
  logic srcPend, dstPend, tcoWr;
  logic [15:0] ctl [2];
  logic [15:0] sc [2];
  logic [AW-1:0] addr [2];
  logic [63:0] mr1 [2];
  chc_pkg::chc_res_type ps [2];
  chc_pkg::chc_res_type pd [2];
  logic [63:0] comparand, mr2;
  logic [15:0] page, devSel, heldInstr;
  chc_pkg::chc_tco_type tcoSel;
  chc_pkg::chc_state_type state;
  logic [63:0] mem [DEPTH];
  logic [DEPTH-1:0] valid, hit;
  logic matchHit, multiHit, fullHit;
  logic [AW-1:0] hpmAddr, nfaAddr, hpmNext, nfaNext;

  // Internal reset also taken by a control-register reset write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      softRst <= 1'b0;
    end else begin
      softRst <= tcoWr && tcoSel == chc_pkg::T_CT &&
                 !hostBusIn[chc_pkg::CT_RESET_BIT];
    end
  end
  assign rstN = rst_b & ~softRst;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      strobeQ <= 1'b1;
    end else begin
      strobeQ <= chipEnableN;
    end
  end
  assign fall = strobeQ & ~chipEnableN;
  assign rise = ~strobeQ & chipEnableN;
  assign cmdWr = fall & ~commandEnableN & ~writeEnableN;
  assign cmdRd = fall & ~commandEnableN & writeEnableN;
  assign datWr = fall & commandEnableN & ~writeEnableN;
  assign datRd = fall & commandEnableN & writeEnableN;
  assign selOk = devSel == page;
  assign wrOk = selOk | (devSel == chc_pkg::DS_ALL);

  // Active set fields
  logic [15:0] ct;
  logic mfOff, ffOff, xlOn;
  logic [1:0] dCur, dStart, dEnd, sCur, sStart, sEnd;
  assign ct = ctl[bank];
  assign mfOff = ct[chc_pkg::CT_MF_LSB +: 2] == chc_pkg::FLAG_OFF;
  assign ffOff = ct[chc_pkg::CT_FF_LSB +: 2] == chc_pkg::FLAG_OFF;
  assign xlOn = ct[chc_pkg::CT_XL_LSB +: 2] == chc_pkg::XLATE_ON;
  assign dCur = sc[bank][chc_pkg::SC_DCUR +: 2];
  assign dStart = sc[bank][chc_pkg::SC_DSTART +: 2];
  assign dEnd = sc[bank][chc_pkg::SC_DEND +: 2];
  assign sCur = sc[bank][chc_pkg::SC_SCUR +: 2];
  assign sStart = sc[bank][chc_pkg::SC_SSTART +: 2];
  assign sEnd = sc[bank][chc_pkg::SC_SEND +: 2];

  function automatic logic [1:0] segNext(input logic [1:0] c,
                                         input logic [1:0] s,
                                         input logic [1:0] e);
    // Past the end limit the count wraps through 3 to 0 first
    segNext = (c == e) ? s : c + 2'h1;
  endfunction

  function automatic logic [15:0] xlate(input logic [15:0] d);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = d[(i & 8) | (7 - (i & 7))];
    end
    return r;
  endfunction

  // Cycle routing
  logic dsWr, instrWr, addrWr, go, dwOk, drOk, memAcc, bankChg;
  logic [15:0] instr, wData;
  logic [AW-1:0] exAddr, stepped;
  chc_pkg::chc_op_type op;
  assign tcoWr = cmdWr & tcoOn & wrOk & ~locked;
  assign dsWr = cmdWr & tcoOn & (tcoSel == chc_pkg::T_DS);
  assign instrWr = cmdWr & ~tcoOn & wrOk & (state == chc_pkg::ST_IDLE);
  assign addrWr = cmdWr & ~tcoOn & wrOk & ~locked &
                  (state == chc_pkg::ST_ADDR);
  assign instr = addrWr ? heldInstr : hostBusIn;
  assign op = chc_pkg::chc_op_type'(instr[15:chc_pkg::OP_LSB]);
  assign go = addrWr | (instrWr & ~hostBusIn[chc_pkg::ADDR_FLAG_BIT] &
              (~locked | op == chc_pkg::OP_NOP));
  assign exAddr = addrWr ? hostBusIn[AW-1:0] : addr[bank];
  assign dwOk = datWr & wrOk & ~locked;
  assign drOk = datRd & selOk;
  assign wData = xlOn ? xlate(hostBusIn) : hostBusIn;
  assign bankChg = go & (op == chc_pkg::OP_SFR | op == chc_pkg::OP_SBR);
  assign memAcc = (dwOk & pd[bank] == chc_pkg::RES_MEM & dCur == dEnd) |
                  (drOk & ps[bank] == chc_pkg::RES_MEM & sCur == sEnd) |
                  (go & op == chc_pkg::OP_VALID);
  always_comb begin
    case (ct[chc_pkg::CT_STEP_LSB +: 2])
      chc_pkg::STEP_INC: stepped = exAddr + AW'(1);
      chc_pkg::STEP_DEC: stepped = exAddr - AW'(1);
      default: stepped = exAddr;
    endcase
  end

  // Configuration state, both register sets
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      for (int b = 0; b < 2; b++) begin
        ctl[b] <= chc_pkg::CT_RESET;
        sc[b] <= chc_pkg::SC_RESET;
        addr[b] <= '0;
        mr1[b] <= '0;
        ps[b] <= chc_pkg::RES_CR;
        pd[b] <= chc_pkg::RES_CR;
      end
      bank <= 1'b0;
      comparand <= '0;
      mr2 <= '0;
      page <= chc_pkg::PAGE_RESET;
      devSel <= chc_pkg::DS_RESET;
      tcoOn <= 1'b0;
      tcoSel <= chc_pkg::T_CT;
      statusHi <= 1'b0;
      cmpReq <= 1'b0;
      state <= chc_pkg::ST_IDLE;
      heldInstr <= '0;
      srcPend <= 1'b0;
      dstPend <= 1'b0;
    end else begin
      cmpReq <= (tcoWr & tcoSel == chc_pkg::T_CT) |
                (dwOk & pd[bank] != chc_pkg::RES_MEM & dCur == dEnd) |
                (go & op == chc_pkg::OP_CMP);
      if (tcoOn && (cmdWr || cmdRd)) begin
        tcoOn <= 1'b0;
      end
      if (fall) begin
        statusHi <= cmdRd && !tcoOn && !statusHi;
        srcPend <= drOk;
        dstPend <= dwOk;
      end
      if (tcoWr) begin
        case (tcoSel)
          chc_pkg::T_CT: ctl[bank] <= {1'b0, hostBusIn[14:0]};
          chc_pkg::T_PA: if (!ffOff) page <= hostBusIn;
          chc_pkg::T_SC: sc[bank] <= hostBusIn & chc_pkg::SC_RD_MASK;
          chc_pkg::T_AR: addr[bank] <= hostBusIn[AW-1:0];
          default: ;
        endcase
      end
      if (dsWr) begin
        devSel <= hostBusIn;
      end
      if (addrWr || memAcc) begin
        addr[bank] <= memAcc ? stepped : exAddr;
      end
      if (dwOk) begin
        case (pd[bank])
          chc_pkg::RES_CR: comparand[{dCur, 4'h0} +: 16] <= wData;
          chc_pkg::RES_MR1: mr1[bank][{dCur, 4'h0} +: 16] <= wData;
          chc_pkg::RES_MR2: mr2[{dCur, 4'h0} +: 16] <= wData;
          default: ;
        endcase
      end
      if (rise && dstPend) begin
        sc[bank][chc_pkg::SC_DCUR +: 2] <=
            segNext(dCur, dStart, dEnd);
        dstPend <= 1'b0;
      end
      if (rise && srcPend) begin
        sc[bank][chc_pkg::SC_SCUR +: 2] <=
            segNext(sCur, sStart, sEnd);
        srcPend <= 1'b0;
      end
      if (go) begin
        case (op)
          chc_pkg::OP_TCO: begin
            tcoOn <= 1'b1;
            tcoSel <= chc_pkg::chc_tco_type'(instr[2:0]);
          end
          chc_pkg::OP_SPS: begin
            ps[bank] <= chc_pkg::chc_res_type'(instr[1:0]);
          end
          chc_pkg::OP_SPD: begin
            pd[bank] <= chc_pkg::chc_res_type'(instr[1:0]);
          end
          chc_pkg::OP_SFR: bank <= 1'b0;
          chc_pkg::OP_SBR: bank <= 1'b1;
          chc_pkg::OP_RSC: begin
            sc[bank][chc_pkg::SC_DCUR +: 2] <= dStart;
            sc[bank][chc_pkg::SC_SCUR +: 2] <= sStart;
          end
          default: ;
        endcase
      end
      case (state)
        chc_pkg::ST_IDLE: begin
          if (instrWr && hostBusIn[chc_pkg::ADDR_FLAG_BIT] && !locked) begin
            state <= chc_pkg::ST_ADDR;
            heldInstr <= hostBusIn;
          end
        end
        chc_pkg::ST_ADDR: if (addrWr) state <= chc_pkg::ST_IDLE;
        default: state <= chc_pkg::ST_IDLE;
      endcase
    end
  end

  // Compare: mask bit high means don't care
  logic [5:0] ramBits;
  logic [63:0] camOff, dontCare;
  assign ramBits = {ct[chc_pkg::CT_CAM_LSB +: 2], 4'h0};
  assign camOff = ct[chc_pkg::CT_RAM_LOW_BIT] ? ~({64{1'b1}} << ramBits) :
                  ~({64{1'b1}} >> ramBits);
  always_comb begin
    case (ct[chc_pkg::CT_MASK_LSB +: 2])
      chc_pkg::MASK_ONE: dontCare = camOff | mr1[bank];
      chc_pkg::MASK_TWO: dontCare = camOff | mr2;
      default: dontCare = camOff;
    endcase
  end
  always_comb begin
    hit = '0;
    hpmNext = '0;
    nfaNext = '0;
    // Downward scan leaves the lowest address, highest priority
    for (int i = DEPTH - 1; i >= 0; i--) begin
      hit[i] = valid[i] & ~|((mem[i] ^ comparand) & ~dontCare);
      if (hit[i]) hpmNext = AW'(i);
      if (!valid[i]) nfaNext = AW'(i);
    end
  end

  logic movGo;
  logic [AW-1:0] movAddr;
  assign movGo = go & ((op == chc_pkg::OP_MOVHPM & matchHit & ~mfOff) |
                 (op == chc_pkg::OP_MOVNF & ~fullHit & ~ffOff));
  assign movAddr = (op == chc_pkg::OP_MOVHPM) ? hpmAddr : nfaAddr;

  // Array has no reset; emptiness is held by the validity bits
  always_ff @(posedge clk) begin
    if (dwOk && pd[bank] == chc_pkg::RES_MEM) begin
      mem[addr[bank]][{dCur, 4'h0} +: 16] <= wData;
    end
    if (movGo) begin
      mem[movAddr] <= comparand;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      valid <= '0;
    end else begin
      if (movGo) valid[movAddr] <= 1'b1;
      if (go && op == chc_pkg::OP_VALID) valid[exAddr] <= instr[0];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      matchHit <= 1'b0;
      multiHit <= 1'b0;
      fullHit <= 1'b0;
      hpmAddr <= '0;
      nfaAddr <= '0;
      locked <= 1'b0;
    end else begin
      fullHit <= &valid;
      nfaAddr <= nfaNext;
      if (bankChg) begin
        matchHit <= 1'b0;
        multiHit <= 1'b0;
      end
      if (cmpReq) begin
        matchHit <= |hit;
        multiHit <= |(hit & (hit - DEPTH'(1)));
        hpmAddr <= hpmNext;
      end
      if (go && op == chc_pkg::OP_NOP) locked <= 1'b0;
      if (cmpReq && !(|hit) &&
          ct[chc_pkg::CT_MODE_LSB +: 2] != chc_pkg::MODE_ENH) begin
        locked <= 1'b1;
      end
    end
  end

  // Read path
  logic [63:0] srcWord;
  logic [15:0] cmdWord;
  always_comb begin
    case (ps[bank])
      chc_pkg::RES_MR1: srcWord = mr1[bank];
      chc_pkg::RES_MR2: srcWord = mr2;
      chc_pkg::RES_MEM: srcWord = mem[addr[bank]];
      default: srcWord = comparand;
    endcase
  end
  always_comb begin
    if (!tcoOn) begin
      cmdWord = statusHi ? {13'h0, fullHit, multiHit, matchHit} :
                16'(hpmAddr);
    end else begin
      case (tcoSel)
        chc_pkg::T_CT: cmdWord = {1'b0, ct[14:0]};
        chc_pkg::T_PA: cmdWord = page;
        chc_pkg::T_SC: cmdWord = sc[bank] & chc_pkg::SC_RD_MASK;
        chc_pkg::T_AR: cmdWord = 16'(addr[bank]);
        chc_pkg::T_NFA: cmdWord = 16'(nfaAddr);
        chc_pkg::T_DS: cmdWord = devSel;
        chc_pkg::T_PS: cmdWord = {14'h0, ps[bank]};
        default: cmdWord = {14'h0, pd[bank]};
      endcase
    end
  end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      hostBusOut <= '0;
      rdLive <= 1'b0;
    end else if (chipEnableN) begin
      rdLive <= 1'b0;
    end else if (cmdRd || datRd) begin
      rdLive <= selOk;
      hostBusOut <= cmdRd ? cmdWord : srcWord[{sCur, 4'h0} +: 16];
    end
  end
  assign hostBusOe = rdLive & ~chipEnableN;

  // Flags
  assign localMatchN = ~matchHit;
  assign multiMatchN = ~multiHit;
  assign chainMatchOe = ~chainEnableN;
  assign chainMatchOutN = chainEnableN |
                          (chainMatchInN & ~(matchHit & ~mfOff));
  assign chainFullOutN = chainFullInN | ~(fullHit | ffOff);

  a_drive_while_low: assert property (@(posedge clk)
    disable iff (!rstN)
    hostBusOe |-> !chipEnableN && $past(!chipEnableN))
    else $error("bus driven outside strobe low");
  a_chain_gate: assert property (@(posedge clk) disable iff (!rstN)
    chainEnableN |-> !chainMatchOe && chainMatchOutN)
    else $error("match out driven while chain disabled");
  a_match_mirror: assert property (@(posedge clk) disable iff (!rstN)
    (mfOff && !chainEnableN) |-> chainMatchOutN == chainMatchInN)
    else $error("match out does not mirror input");
  a_full_mirror: assert property (@(posedge clk) disable iff (!rstN)
    ffOff |-> chainFullOutN == chainFullInN)
    else $error("full out does not mirror input");
  a_ct_top_zero: assert property (@(posedge clk) disable iff (!rstN)
    (cmdRd && selOk && tcoOn && tcoSel == chc_pkg::T_CT)
    |=> !hostBusOut[15])
    else $error("control bit 15 read as one");
  a_tco_once: assert property (@(posedge clk) disable iff (!rstN)
    (tcoOn && (cmdWr || cmdRd)) |=> !tcoOn)
    else $error("override lasted past one cycle");
  a_status_pair: assert property (@(posedge clk) disable iff (!rstN)
    $rose(statusHi) |-> $past(cmdRd && !tcoOn))
    else $error("upper status without low read");
  a_addr_wait: assert property (@(posedge clk) disable iff (!rstN)
    (instrWr && !locked && hostBusIn[chc_pkg::ADDR_FLAG_BIT])
    |=> state == chc_pkg::ST_ADDR ##0 !cmpReq)
    else $error("flagged instruction did not wait");
  a_ct_compare: assert property (@(posedge clk) disable iff (!rstN)
    (tcoWr && tcoSel == chc_pkg::T_CT && hostBusIn[15]) |=> cmpReq ##1
    localMatchN == !$past(|hit))
    else $error("control write gave no compare");
  a_lock_hold: assert property (@(posedge clk) disable iff (!rstN)
    (locked && datWr) |=> $stable(comparand) && $stable(mr2))
    else $error("write taken while chain locked");
endmodule
`default_nettype wire

// File: tb/chc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module chc_host_model (
  // Clock
  input wire logic clk,
  // Host control bus
  output logic chipEnableN,
  output logic writeEnableN,
  output logic commandEnableN,
  // Host data bus
  output logic [15:0] hostBusIn,
  input wire logic [15:0] hostBusOut,
  input wire logic hostBusOe
);
  logic [15:0] lastBus;
  initial begin
    chipEnableN = 1'b1;
    writeEnableN = 1'b1;
    commandEnableN = 1'b1;
    hostBusIn = 16'h0000;
    lastBus = 16'h0000;
  end
  // Strobe low for two edges, then high for at least one
  task automatic cycle(input logic cmd, input logic wr,
      input logic [15:0] data, output logic [15:0] rd, output logic oe);
    @(posedge clk);
    chipEnableN <= 1'b0;
    commandEnableN <= ~cmd;
    writeEnableN <= ~wr;
    // Released bus shows the inverse, never a stale copy
    hostBusIn <= wr ? data : ~lastBus;
    if (wr) lastBus = data;
    @(posedge clk);
    #1;
    rd = hostBusOut;
    oe = hostBusOe;
    @(posedge clk);
    chipEnableN <= 1'b1;
    hostBusIn <= ~lastBus;
  endtask
endmodule
`default_nettype wire

// File: tb/chc_command_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module chc_command_control_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic chipEnableN, writeEnableN, commandEnableN;
  logic [15:0] hostBusIn, hostBusOut;
  logic hostBusOe, chainMatchOutN, chainMatchOe, chainFullOutN;
  logic localMatchN, multiMatchN;
  logic chainEnableN = 1'b0;
  logic chainMatchInN = 1'b1;
  logic chainFullInN = 1'b0;
  int failures = 0;
  int nCompared = 0;
  int seed;
  int q[$];
  logic [15:0] v, a;

  initial begin
    forever #2.5 clk = ~clk;
  end

  chc_command_control #(.DEPTH(16), .AW(4)) chc_command_control_inst (
    .clk(clk), .rst_b(rst_b), .chipEnableN(chipEnableN),
    .writeEnableN(writeEnableN), .commandEnableN(commandEnableN),
    .hostBusIn(hostBusIn), .hostBusOut(hostBusOut), .hostBusOe(hostBusOe),
    .chainEnableN(chainEnableN), .chainMatchInN(chainMatchInN),
    .chainFullInN(chainFullInN), .chainMatchOutN(chainMatchOutN),
    .chainMatchOe(chainMatchOe), .chainFullOutN(chainFullOutN),
    .localMatchN(localMatchN), .multiMatchN(multiMatchN)
  );

  chc_host_model chc_host_model_inst (
    .clk(clk), .chipEnableN(chipEnableN), .writeEnableN(writeEnableN),
    .commandEnableN(commandEnableN), .hostBusIn(hostBusIn),
    .hostBusOut(hostBusOut), .hostBusOe(hostBusOe)
  );

  task automatic complete_run();
    $display("compared %0d failures %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    nCompared++;
    if (g !== e) begin
      failures++;
      $display("mismatch %0s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cw(input logic [15:0] d);
    logic [15:0] r;
    logic o;
    chc_host_model_inst.cycle(1'b1, 1'b1, d, r, o);
  endtask

  task automatic dw(input logic [15:0] d);
    logic [15:0] r;
    logic o;
    chc_host_model_inst.cycle(1'b0, 1'b1, d, r, o);
  endtask

  // A refused read shows as a mismatch through the enable
  task automatic rdc(input logic cmd, input string nm,
      input logic [15:0] e);
    logic [15:0] r;
    logic o;
    chc_host_model_inst.cycle(cmd, 1'b0, 16'h0000, r, o);
    check(nm, e, (o === 1'b1) ? r : ~e);
  endtask

  task automatic done(input string nm);
    $display("test %0s done", nm);
  endtask

  // Each strobe cycle takes three edges; the run needs a few hundred
  initial begin
    #100000;
    failures++;
    complete_run();
  end

  initial begin
    seed = 32'h8648;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    cw(16'h1000);
    rdc(1'b1, "ct reset", 16'h0000);
    cw(16'h1002);
    rdc(1'b1, "sc reset", 16'h60C0);
    cw(16'h1006);
    rdc(1'b1, "ps reset", 16'h0000);
    cw(16'h1002);
    rdc(1'b1, "sc override", 16'h60C0);
    rdc(1'b1, "status low", 16'h0000);
    rdc(1'b1, "status high", 16'h0000);
    done("reset");
    // Comparand write misses; standard mode locks the chain
    for (int s = 0; s < 4; s++) begin
      v = 16'($random(seed));
      q.push_back(int'(v));
      dw(v);
    end
    dw(~v);
    cw(16'h2001);
    cw(16'h0000);
    cw(16'h1006);
    rdc(1'b1, "ps locked", 16'h0000);
    cw(16'h1000);
    cw(16'h8001);
    cw(16'h1000);
    rdc(1'b1, "ct enhanced", 16'h0001);
    // Write refused while locked leaves the earlier comparand
    for (int s = 0; s < 4; s++) begin
      rdc(1'b0, "cr kept", 16'(q.pop_front()));
    end
    done("lock");
    for (int r = 0; r < 4; r++) begin
      cw(16'h3000 | 16'(r));
      cw(16'h2000 | 16'(r));
      for (int s = 0; s < 4; s++) begin
        v = 16'($random(seed));
        q.push_back(int'(v));
        dw(v);
      end
      for (int s = 0; s < 4; s++) begin
        rdc(1'b0, "segment", 16'(q.pop_front()));
      end
      cw(16'h1007);
      rdc(1'b1, "pd", 16'(r));
    end
    done("resources");
    cw(16'h5000);
    cw(16'h1000);
    rdc(1'b1, "ct background", 16'h0000);
    cw(16'h1006);
    rdc(1'b1, "ps background", 16'h0000);
    cw(16'h4000);
    cw(16'h1000);
    rdc(1'b1, "ct foreground", 16'h0001);
    done("sets");
    cw(16'h1000);
    cw(16'h8005);
    a = 16'($random(seed)) & 16'h0007;
    cw(16'h8800);
    cw(a);
    cw(16'h1003);
    rdc(1'b1, "ar step", a + 16'h0001);
    #1;
    check("full out", 16'h0001, {15'h0, chainFullOutN});
    done("address");
    // Store a word at the stepped address, mark it, then hit it
    cw(16'h3003);
    for (int s = 0; s < 4; s++) begin
      v = 16'($random(seed));
      q.push_back(int'(v));
      dw(v);
    end
    cw(16'h8801);
    cw(a + 16'h0001);
    cw(16'h3000);
    for (int s = 0; s < 4; s++) begin
      dw(16'(q.pop_front()));
    end
    #1;
    check("local match", 16'h0000, 16'(localMatchN));
    check("multi match", 16'h0001, 16'(multiMatchN));
    rdc(1'b1, "hpm address", a + 16'h0001);
    rdc(1'b1, "match status", 16'h0001);
    done("match");
    cw(16'h1000);
    cw(16'hA801);
    cw(16'h1001);
    cw(16'h0003);
    cw(16'h1001);
    rdc(1'b1, "page held", 16'h0000);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      chainEnableN <= i[2];
      chainMatchInN <= i[0];
      chainFullInN <= i[1];
      @(posedge clk);
      #1;
      check("match oe", {15'h0, ~chainEnableN}, {15'h0, chainMatchOe});
      v = 16'(chainEnableN | chainMatchInN);
      check("match out", v, 16'(chainMatchOutN));
      check("full mirror", 16'(chainFullInN), 16'(chainFullOutN));
      check("local match", 16'h0000, 16'(localMatchN));
    end
    @(posedge clk);
    chainEnableN <= 1'b0;
    done("flags");
    cw(16'h1000);
    cw(16'h7FFF);
    cw(16'h1000);
    rdc(1'b1, "ct soft reset", 16'h0000);
    cw(16'h1007);
    rdc(1'b1, "pd soft reset", 16'h0000);
    done("soft reset");
    complete_run();
  end
endmodule
`default_nettype wire
